// [src/cmh_mailbox.sv]
// Console mailbox registers, interlock flags, interrupts and maintenance cycles.
// How it works
// - Console sets receive done, host gets interrupt.
// - Host read clears done, interrupts console.
// - Setting transmit ready interrupts the host.
// - Host write clears ready, interrupts console.
// - Console I/O mode gives host no interrupts.
// - Return enable write pops stack, forces jump.
// - Freeze bit holds host interrupt state.
// - Running-clock maintenance write stores both words.
// - Running-clock maintenance read fills host words.
// - Stopped-clock read shows live data once out of time state zero.
// - No bus strobes in time state zero.
// - Stopped write steps one cycle, clears maintenance.
// - Transmit interrupt to console needs its enable.
// - Proceed in single cycle mode steps cycle.
module cmh_mailbox
   import cmh_pkg::*;
#(
   parameter int IB_ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic host_rx_read,
   output logic [DATA_W-1:0] host_rx_data,
   input wire logic host_tx_write,
   input wire logic [DATA_W-1:0] host_tx_data,
   output logic host_rx_done,
   output logic host_tx_ready,
   output logic host_rx_irq,
   output logic host_tx_irq,
   output logic uc_pop_jump,
   output logic console_irq,
   output logic [IB_ADDR_W-1:0] ib_addr,
   output logic [DATA_W-1:0] ib_wdata,
   output logic ib_wr_stb,
   output logic ib_rd_en,
   input wire logic [DATA_W-1:0] ib_rdata,
   input wire logic halt_state_pin
);
   if (IB_ADDR_W < 1 || IB_ADDR_W > IBCS_WRITE_BIT) begin : g_chk
      $error("IB_ADDR_W must lie between 1 and the write bit position");
   end

   cmh_seq_if sq();

   cmh_seq u_seq (
      .mclk(mclk),
      .rst(rst),
      .sq(sq.seq)
   );

   function automatic logic wr_hit(input logic go, input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
      return go && (a == ofs);
   endfunction

   logic wr_go;
   logic sync_ok;
   logic [HALF_W-1:0] h2c_lo, h2c_hi, c2h_lo, c2h_hi, live_lo, live_hi;
   logic rx_done, tx_ready, next_rx_done, next_tx_ready;
   logic rx_set_ev, tx_set_ev, rx_clr_con, tx_clr_con;
   logic rx_ie, transmit_interrupt_enable, next_rx_ie, next_transmit_interrupt_enable;
   logic rx_pend, tx_pend, next_rx_pend, next_tx_pend;
   logic next_host_rx_irq, next_host_tx_irq;
   logic single_bus_cycle_mode, sts, cio_mode, freeze, proceed;
   logic halt_meta, halt_sync;
   logic [IB_ADDR_W-1:0] ib_sel_addr;
   logic ib_write, cyc_req, maint, cyc_active, maint_wrote, bus_act;
   logic at_zero, cyc_start, cyc_end, cyc_capture, wr_fire;
   logic [DATA_W-1:0] rd_mux;

   // Console accesses are taken only outside the run state or in its sync time state.
   assign sync_ok = !sq.running || (sq.cpt == CPT_SYNC);
   assign wr_go = avs_write && !avs_waitrequest;

   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else if (avs_waitrequest && (avs_read || avs_write) && sync_ok) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rd_mux : '0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_comb begin
      case (avs_address)
         OFS_RX_DONE: rd_mux = DATA_W'(rx_done);
         OFS_TX_READY: rd_mux = DATA_W'(tx_ready);
         OFS_H2C_LO: rd_mux = DATA_W'(h2c_lo);
         OFS_H2C_HI: rd_mux = DATA_W'(h2c_hi);
         OFS_C2H_LO: rd_mux = DATA_W'(c2h_lo);
         OFS_C2H_HI: rd_mux = DATA_W'(c2h_hi);
         OFS_LIVE_LO: rd_mux = DATA_W'(live_lo);
         OFS_LIVE_HI: rd_mux = DATA_W'(live_hi);
         OFS_IBCS: begin
            rd_mux = DATA_W'(ib_sel_addr);
            rd_mux[IBCS_WRITE_BIT] = ib_write;
            rd_mux[IBCS_CYCLE_BIT] = cyc_req;
            rd_mux[IBCS_MAINT_BIT] = maint;
         end
         OFS_MCR: begin
            rd_mux = '0;
            rd_mux[MCR_SBC_BIT] = single_bus_cycle_mode;
            rd_mux[MCR_STS_BIT] = sts;
            rd_mux[MCR_CIO_BIT] = cio_mode;
            rd_mux[MCR_FREEZE_BIT] = freeze;
            rd_mux[MCR_HALT_BIT] = halt_sync;
         end
         OFS_MCS: begin
            rd_mux = '0;
            rd_mux[MCS_RX_CLR_BIT] = rx_pend;
            rd_mux[MCS_RX_IE_BIT] = rx_ie;
            rd_mux[MCS_TRANSMIT_INTERRUPT_ENABLE_BIT] = transmit_interrupt_enable;
            rd_mux[MCS_TX_CLR_BIT] = tx_pend;
         end
         default: rd_mux = '0;
      endcase
   end

   // Interlock flags; a console set wins over a host clear in the same cycle.
   always_comb begin
      rx_set_ev = wr_hit(wr_go, avs_address, OFS_RX_DONE) && avs_writedata[FLAG_BIT];
      rx_clr_con = wr_hit(wr_go, avs_address, OFS_RX_DONE) && !avs_writedata[FLAG_BIT];
      tx_set_ev = wr_hit(wr_go, avs_address, OFS_TX_READY) && avs_writedata[FLAG_BIT];
      tx_clr_con = wr_hit(wr_go, avs_address, OFS_TX_READY) && !avs_writedata[FLAG_BIT];
      next_rx_done = rx_done;
      if (rx_set_ev) begin
         next_rx_done = 1'b1;
      end else if (host_rx_read || rx_clr_con) begin
         next_rx_done = 1'b0;
      end
      next_tx_ready = tx_ready;
      if (tx_set_ev) begin
         next_tx_ready = 1'b1;
      end else if (host_tx_write || tx_clr_con) begin
         next_tx_ready = 1'b0;
      end
   end

   // Host interrupts fire on a flag set in program I/O mode and freeze under the hold bit.
   always_comb begin
      next_host_rx_irq = host_rx_irq;
      next_host_tx_irq = host_tx_irq;
      if (!freeze) begin
         if (rx_set_ev && !cio_mode) begin
            next_host_rx_irq = 1'b1;
         end else if (host_rx_read || !rx_done) begin
            next_host_rx_irq = 1'b0;
         end
         if (tx_set_ev && !cio_mode) begin
            next_host_tx_irq = 1'b1;
         end else if (host_tx_write || !tx_ready) begin
            next_host_tx_irq = 1'b0;
         end
      end
   end

   // Console interrupts fire on a one-to-zero flag edge while enabled or an enable rising over a low flag.
   always_comb begin
      next_rx_ie = rx_ie;
      next_transmit_interrupt_enable = transmit_interrupt_enable;
      if (wr_hit(wr_go, avs_address, OFS_MCS)) begin
         next_rx_ie = avs_writedata[MCS_RX_IE_BIT];
         next_transmit_interrupt_enable = avs_writedata[MCS_TRANSMIT_INTERRUPT_ENABLE_BIT];
      end
      next_rx_pend = rx_pend;
      if ((rx_done && !next_rx_done && rx_ie) || (!rx_ie && next_rx_ie && !rx_done)) begin
         next_rx_pend = 1'b1;
      end else if (!next_rx_ie || (wr_hit(wr_go, avs_address, OFS_MCS)
                                   && avs_writedata[MCS_RX_CLR_BIT])) begin
         next_rx_pend = 1'b0;
      end
      next_tx_pend = tx_pend;
      if ((tx_ready && !next_tx_ready && transmit_interrupt_enable) || (!transmit_interrupt_enable && next_transmit_interrupt_enable && !tx_ready)) begin
         next_tx_pend = 1'b1;
      end else if (!next_transmit_interrupt_enable || (wr_hit(wr_go, avs_address, OFS_MCS)
                                   && avs_writedata[MCS_TX_CLR_BIT])) begin
         next_tx_pend = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_done <= RST_RX_DONE;
         tx_ready <= RST_TX_READY;
         host_rx_irq <= 1'b0;
         host_tx_irq <= 1'b0;
         rx_ie <= 1'b0;
         transmit_interrupt_enable <= 1'b0;
         rx_pend <= 1'b0;
         tx_pend <= 1'b0;
         console_irq <= 1'b0;
      end else begin
         rx_done <= next_rx_done;
         tx_ready <= next_tx_ready;
         host_rx_irq <= next_host_rx_irq;
         host_tx_irq <= next_host_tx_irq;
         rx_ie <= next_rx_ie;
         transmit_interrupt_enable <= next_transmit_interrupt_enable;
         rx_pend <= next_rx_pend;
         tx_pend <= next_tx_pend;
         console_irq <= next_rx_pend || next_tx_pend;
      end
   end

   assign host_rx_done = rx_done;
   assign host_tx_ready = tx_ready;
   assign host_rx_data = {h2c_hi, h2c_lo};

   // Machine control bits, the proceed and return enable pulses, and the halt state input.
   always_ff @(posedge mclk) begin
      if (rst) begin
         single_bus_cycle_mode <= 1'b0;
         sts <= 1'b0;
         cio_mode <= 1'b0;
         freeze <= 1'b0;
         proceed <= 1'b0;
         uc_pop_jump <= 1'b0;
      end else begin
         proceed <= wr_hit(wr_go, avs_address, OFS_MCR) && avs_writedata[MCR_PROCEED_BIT];
         uc_pop_jump <= wr_hit(wr_go, avs_address, OFS_MCR) && avs_writedata[MCR_RET_BIT];
         if (wr_hit(wr_go, avs_address, OFS_MCR)) begin
            single_bus_cycle_mode <= avs_writedata[MCR_SBC_BIT];
            sts <= avs_writedata[MCR_STS_BIT];
            cio_mode <= avs_writedata[MCR_CIO_BIT];
            freeze <= avs_writedata[MCR_FREEZE_BIT];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         halt_meta <= 1'b0;
         halt_sync <= 1'b0;
      end else begin
         halt_meta <= halt_state_pin;
         halt_sync <= halt_meta;
      end
   end

   assign sq.single_bus_cycle_mode = single_bus_cycle_mode;
   assign sq.sts = sts;
   assign sq.proceed = proceed;

   // Internal bus maintenance cycles run from one entry into time state zero to the next.
   assign at_zero = sq.ts_enter && (sq.cpt == CPT_ZERO);
   assign cyc_start = cyc_req && sq.running && at_zero && !cyc_active;
   assign cyc_end = cyc_active && at_zero;
   assign cyc_capture = cyc_active && !ib_write && sq.ts_enter && (sq.cpt == CPT_LAST);
   assign bus_act = cyc_active || maint;
   assign wr_fire = bus_act && ib_write && sq.ts_enter && (sq.cpt == CPT_WR);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ib_sel_addr <= '0;
         ib_write <= 1'b0;
         cyc_req <= 1'b0;
         maint <= 1'b0;
         cyc_active <= 1'b0;
         maint_wrote <= 1'b0;
      end else begin
         if (wr_hit(wr_go, avs_address, OFS_IBCS)) begin
            ib_sel_addr <= avs_writedata[IB_ADDR_W-1:0];
            ib_write <= avs_writedata[IBCS_WRITE_BIT];
            cyc_req <= avs_writedata[IBCS_CYCLE_BIT];
            maint <= avs_writedata[IBCS_MAINT_BIT];
         end else begin
            if (cyc_end) begin
               cyc_req <= 1'b0;
            end
            if (maint_wrote && at_zero) begin
               maint <= 1'b0;
            end
         end
         if (cyc_start) begin
            cyc_active <= 1'b1;
         end else if (cyc_end) begin
            cyc_active <= 1'b0;
         end
         if (wr_fire && maint) begin
            maint_wrote <= 1'b1;
         end else if (at_zero || !maint) begin
            maint_wrote <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ib_addr <= '0;
         ib_wdata <= '0;
         ib_wr_stb <= 1'b0;
         ib_rd_en <= 1'b0;
      end else begin
         ib_addr <= ib_sel_addr;
         ib_wdata <= {h2c_hi, h2c_lo};
         ib_wr_stb <= wr_fire;
         ib_rd_en <= bus_act && !ib_write && (sq.cpt != CPT_ZERO);
      end
   end

   // Mailbox data words.
   always_ff @(posedge mclk) begin
      if (rst) begin
         h2c_lo <= '0;
         h2c_hi <= '0;
         c2h_lo <= '0;
         c2h_hi <= '0;
         live_lo <= '0;
         live_hi <= '0;
      end else begin
         if (wr_hit(wr_go, avs_address, OFS_H2C_LO)) begin
            h2c_lo <= avs_writedata[HALF_W-1:0];
         end
         if (wr_hit(wr_go, avs_address, OFS_H2C_HI)) begin
            h2c_hi <= avs_writedata[HALF_W-1:0];
         end
         if (cyc_capture) begin
            {c2h_hi, c2h_lo} <= ib_rdata;
         end else if (host_tx_write) begin
            {c2h_hi, c2h_lo} <= host_tx_data;
         end
         if (maint && !ib_write && ib_rd_en) begin
            {live_hi, live_lo} <= ib_rdata;
         end
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   chk_rx_host_irq: assert property ((rx_set_ev && !cio_mode && !freeze) |=> host_rx_irq)
      else $error("receive done set gave no host interrupt");
   chk_rx_read_clear: assert property (
      (host_rx_read && !rx_set_ev && rx_done && rx_ie) |=> (!rx_done && console_irq))
      else $error("host read did not clear done and interrupt the console");
   chk_tx_host_irq: assert property ((tx_set_ev && !cio_mode && !freeze) |=> host_tx_irq)
      else $error("transmit ready set gave no host interrupt");
   chk_tx_write_clear: assert property (
      (host_tx_write && !tx_set_ev && !cyc_capture)
      |=> (!tx_ready && {c2h_hi, c2h_lo} == $past(host_tx_data)))
      else $error("host write did not load data and clear ready");
   chk_cio_no_irq: assert property (
      (cio_mode && !host_rx_irq && !host_tx_irq) |=> (!host_rx_irq && !host_tx_irq))
      else $error("host interrupt raised in console I/O mode");
   chk_freeze_hold: assert property (
      freeze |=> ($stable(host_rx_irq) && $stable(host_tx_irq)))
      else $error("host interrupt state changed while frozen");
   chk_ret_pulse: assert property (
      (wr_hit(wr_go, avs_address, OFS_MCR) && avs_writedata[MCR_RET_BIT])
      |=> uc_pop_jump ##1 !uc_pop_jump)
      else $error("return enable write gave no single jump pulse");
   chk_no_strobe_zero: assert property ($past(sq.cpt) == CPT_ZERO |-> !ib_rd_en)
      else $error("read strobe enabled in time state zero");
   chk_transmit_interrupt_enable_rise: assert property (
      (!transmit_interrupt_enable && next_transmit_interrupt_enable && !tx_ready) |=> (console_irq && tx_pend))
      else $error("enable rising over low ready gave no console interrupt");
   chk_maint_clear: assert property (
      (maint_wrote && at_zero && !wr_hit(wr_go, avs_address, OFS_IBCS)) |=> !maint)
      else $error("maintenance bit not cleared after stopped write");
   chk_accept_sync: assert property (!avs_waitrequest |-> $past(sync_ok))
      else $error("console access taken outside a sync point");
endmodule // cmh_mailbox

// [src/cmh_pkg.sv]
// Shared constants and types of the console mailbox block.
package cmh_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int TS_W = 2;
   localparam logic [ADDR_W-1:0] OFS_RX_DONE = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_TX_READY = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_H2C_LO = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_H2C_HI = 6'h0c;
   localparam logic [ADDR_W-1:0] OFS_C2H_LO = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_C2H_HI = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_LIVE_LO = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_LIVE_HI = 6'h1c;
   localparam logic [ADDR_W-1:0] OFS_IBCS = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_MCR = 6'h24;
   localparam logic [ADDR_W-1:0] OFS_MCS = 6'h28;
   localparam int FLAG_BIT = 0;
   localparam int IBCS_WRITE_BIT = 8;
   localparam int IBCS_CYCLE_BIT = 9;
   localparam int IBCS_MAINT_BIT = 10;
   localparam int MCR_PROCEED_BIT = 0;
   localparam int MCR_SBC_BIT = 1;
   localparam int MCR_STS_BIT = 2;
   localparam int MCR_RET_BIT = 3;
   localparam int MCR_CIO_BIT = 4;
   localparam int MCR_FREEZE_BIT = 8;
   localparam int MCR_HALT_BIT = 10;
   localparam int MCS_RX_CLR_BIT = 4;
   localparam int MCS_RX_IE_BIT = 5;
   localparam int MCS_TRANSMIT_INTERRUPT_ENABLE_BIT = 6;
   localparam int MCS_TX_CLR_BIT = 7;
   localparam logic [TS_W-1:0] CPT_ZERO = 2'h0;
   localparam logic [TS_W-1:0] CPT_SYNC = 2'h1;
   localparam logic [TS_W-1:0] CPT_WR = 2'h2;
   localparam logic [TS_W-1:0] CPT_LAST = 2'h3;
   localparam logic RST_RX_DONE = 1'b0;
   localparam logic RST_TX_READY = 1'b1;
   typedef enum logic [1:0] {
      CMH_STOPPED = 2'b00,
      CMH_RUNNING = 2'b01,
      CMH_CYCLE = 2'b10
   } cmh_clk_e;
endpackage

// [src/cmh_seq_if.sv]
// Interface between the register logic and the time-state sequencer.
interface cmh_seq_if;
   import cmh_pkg::*;
   logic single_bus_cycle_mode;
   logic sts;
   logic proceed;
   logic [TS_W-1:0] cpt;
   logic ts_enter;
   logic running;
   modport seq(input single_bus_cycle_mode, input sts, input proceed, output cpt, output ts_enter, output running);
   modport ctl(output single_bus_cycle_mode, output sts, output proceed, input cpt, input ts_enter, input running);
endinterface

// [src/cmh_seq.sv]
// Host clock time-state sequencer with run, single cycle and single state stepping.
module cmh_seq
   import cmh_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   cmh_seq_if.seq sq
);
   cmh_clk_e state;
   cmh_clk_e next_state;
   logic [TS_W-1:0] cpt;
   logic advance;
   logic ts_enter;

   // The clock stops in time state zero under single cycle mode and steps on proceed.
   always_comb begin
      next_state = state;
      advance = 1'b0;
      case (state)
         CMH_RUNNING: begin
            advance = 1'b1;
            if (sq.sts) begin
               next_state = CMH_STOPPED;
            end else if (sq.single_bus_cycle_mode && cpt == CPT_LAST) begin
               next_state = CMH_STOPPED;
            end
         end
         CMH_CYCLE: begin
            advance = 1'b1;
            if (cpt == CPT_LAST) begin
               next_state = CMH_STOPPED;
            end
         end
         CMH_STOPPED: begin
            advance = sq.proceed && sq.sts;
            if (sq.proceed && !sq.sts) begin
               next_state = sq.single_bus_cycle_mode ? CMH_CYCLE : CMH_RUNNING;
            end
         end
         default: begin
            next_state = CMH_STOPPED;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= CMH_RUNNING;
         cpt <= CPT_ZERO;
         ts_enter <= 1'b0;
      end else begin
         state <= next_state;
         cpt <= advance ? cpt + 2'h1 : cpt;
         ts_enter <= advance;
      end
   end

   assign sq.cpt = cpt;
   assign sq.ts_enter = ts_enter;
   assign sq.running = (state == CMH_RUNNING);

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   chk_step_one_cycle: assert property (
      (state == CMH_STOPPED && sq.proceed && sq.single_bus_cycle_mode && !sq.sts)
      |=> (state == CMH_CYCLE) [*4] ##1 (state == CMH_STOPPED && cpt == CPT_ZERO))
      else $error("single cycle step did not end in time state zero");
   chk_step_one_state: assert property (
      (state == CMH_STOPPED && sq.proceed && sq.sts)
      |=> (state == CMH_STOPPED && cpt == $past(cpt) + 2'h1))
      else $error("time state step did not advance by one");
endmodule // cmh_seq

// [tb/cmh_ib_model.sv]
// Behavioural model of the internal register bus behind the mailbox.
module cmh_ib_model (
   input wire logic mclk,
   input wire logic [7:0] ib_addr,
   input wire logic [31:0] ib_wdata,
   input wire logic ib_wr_stb,
   input wire logic ib_rd_en,
   output logic [31:0] ib_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [256];
   logic [31:0] last;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 32'h0f000000 | i;
      last = 32'h0;
   end
   // The addressed register takes the data on the write strobe.
   always @(posedge mclk) begin
      if (ib_wr_stb) mem[ib_addr] <= ib_wdata;
      if (ib_rd_en) last <= mem[ib_addr];
   end
   // A released bus shows the inverse of the last value, never a stale copy.
   always_comb ib_rdata = ib_rd_en ? mem[ib_addr] : ~last;
endmodule // cmh_ib_model

// [tb/tb_top.sv]
// Self-checking testbench of the console mailbox block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cmh_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [ADDR_W-1:0] avs_address = 6'h0;
   logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata, host_rx_data, ib_wdata, ib_rdata;
   logic host_rx_read = 1'b0, host_tx_write = 1'b0, halt_state_pin = 1'b0;
   logic [DATA_W-1:0] host_tx_data = 32'h0, q;
   logic host_rx_done, host_tx_ready, host_rx_irq, host_tx_irq, uc_pop_jump, console_irq;
   logic [7:0] ib_addr;
   logic ib_wr_stb, ib_rd_en;
   int error_cnt = 0, samples_checked = 0, pops = 0;
   always #4 mclk = ~mclk;
   cmh_mailbox uut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .host_rx_read, .host_rx_data, .host_tx_write,
      .host_tx_data, .host_rx_done, .host_tx_ready, .host_rx_irq, .host_tx_irq, .uc_pop_jump,
      .console_irq, .ib_addr, .ib_wdata, .ib_wr_stb, .ib_rd_en, .ib_rdata, .halt_state_pin);
   cmh_ib_model ibm (.mclk, .ib_addr, .ib_wdata, .ib_wr_stb, .ib_rd_en, .ib_rdata);
   always @(posedge mclk) if (uc_pop_jump === 1'b1) pops <= pops + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is sampled low at a rising edge.
   task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 100) chk(32'h0, 32'h1);
      @(posedge mclk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      av(1'b1, a, d);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic rx_pulse();
      host_rx_read <= 1'b1;
      wt(1);
      host_rx_read <= 1'b0;
      wt(3);
   endtask
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         av(1'b0, OFS_IBCS, 32'h0);
         n++;
      end while (q[b] !== 1'b0 && n < 20);
      chk({31'h0, q[b]}, 32'h0);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      wt(12);
      rst <= 1'b0;
      wt(2);
      chk({host_rx_done, host_tx_ready, host_rx_irq, host_tx_irq, console_irq}, 32'h8);
      rdc(OFS_RX_DONE, 32'h0);
      rdc(OFS_TX_READY, 32'h1);
      rdc(6'h3c, 32'h0);
      $display("test reset done");
      wr(OFS_MCS, 32'h20);
      wr(OFS_MCS, 32'h30);
      wr(OFS_H2C_LO, 32'h41);
      wr(OFS_H2C_HI, 32'h0);
      wr(OFS_RX_DONE, 32'h1);
      wt(3);
      chk({host_rx_done, host_rx_irq, console_irq}, 32'h6);
      chk(host_rx_data, 32'h41);
      rx_pulse();
      chk({host_rx_done, host_rx_irq, console_irq}, 32'h1);
      rdc(OFS_MCS, 32'h30);
      wr(OFS_MCS, 32'h30);
      wr(OFS_H2C_LO, 32'h42);
      wr(OFS_RX_DONE, 32'h1);
      wt(3);
      chk({host_rx_done, host_rx_irq, console_irq}, 32'h6);
      rx_pulse();
      wr(OFS_MCS, 32'h10);
      $display("test receive done");
      wr(OFS_MCS, 32'h40);
      wr(OFS_TX_READY, 32'h1);
      wt(3);
      chk({host_tx_ready, host_tx_irq, console_irq}, 32'h6);
      host_tx_data <= 32'h1234abcd;
      host_tx_write <= 1'b1;
      wt(1);
      host_tx_write <= 1'b0;
      wt(3);
      chk({host_tx_ready, host_tx_irq, console_irq}, 32'h1);
      rdc(OFS_C2H_LO, 32'habcd);
      rdc(OFS_C2H_HI, 32'h1234);
      wr(OFS_MCS, 32'h80);
      chk({31'h0, console_irq}, 32'h0);
      wr(OFS_MCS, 32'h40);
      chk({31'h0, console_irq}, 32'h1);
      wr(OFS_MCS, 32'h80);
      $display("test transmit done");
      wr(OFS_MCR, 32'h10);
      wr(OFS_TX_READY, 32'h1);
      wr(OFS_RX_DONE, 32'h1);
      wt(4);
      chk({host_tx_ready, host_rx_done, host_tx_irq, host_rx_irq}, 32'hc);
      rx_pulse();
      wr(OFS_MCR, 32'h0);
      wr(OFS_RX_DONE, 32'h1);
      wt(3);
      wr(OFS_MCR, 32'h100);
      rx_pulse();
      chk({host_rx_done, host_rx_irq}, 32'h1);
      wr(OFS_MCR, 32'h0);
      wt(3);
      chk({31'h0, host_rx_irq}, 32'h0);
      $display("test modes done");
      wr(OFS_MCR, 32'h8);
      wt(3);
      chk(pops, 32'h1);
      halt_state_pin <= 1'b1;
      wt(4);
      av(1'b0, OFS_MCR, 32'h0);
      chk(q & 32'h400, 32'h400);
      rdc(OFS_TX_READY, 32'h1);
      rdc(OFS_RX_DONE, 32'h0);
      halt_state_pin <= 1'b0;
      wr(OFS_H2C_LO, 32'h5555);
      wr(OFS_H2C_HI, 32'haaaa);
      wr(OFS_IBCS, 32'h305);
      poll(IBCS_CYCLE_BIT);
      chk(ibm.mem[5], 32'haaaa5555);
      wr(OFS_IBCS, 32'h206);
      poll(IBCS_CYCLE_BIT);
      rdc(OFS_C2H_LO, 32'h0006);
      rdc(OFS_C2H_HI, 32'h0f00);
      $display("test running maintenance done");
      wr(OFS_MCR, 32'h2);
      wt(8);
      wr(OFS_H2C_LO, 32'h1111);
      wr(OFS_H2C_HI, 32'h2222);
      wr(OFS_IBCS, 32'h507);
      wr(OFS_MCR, 32'h3);
      poll(IBCS_MAINT_BIT);
      chk(ibm.mem[7], 32'h22221111);
      wr(OFS_IBCS, 32'h405);
      wt(3);
      chk({31'h0, ib_rd_en}, 32'h0);
      wr(OFS_MCR, 32'h7);
      wt(3);
      chk({31'h0, ib_rd_en}, 32'h1);
      rdc(OFS_LIVE_LO, 32'h5555);
      rdc(OFS_LIVE_HI, 32'haaaa);
      wr(OFS_IBCS, 32'h407);
      wt(3);
      rdc(OFS_LIVE_LO, 32'h1111);
      rdc(OFS_LIVE_HI, 32'h2222);
      wr(OFS_IBCS, 32'h0);
      wr(OFS_TX_READY, 32'h1);
      chk({31'h0, host_tx_irq}, 32'h1);
      wr(OFS_MCS, 32'h60);
      wr(OFS_MCR, 32'h9);
      wt(3);
      chk(pops, 32'h2);
      $display("test stopped maintenance done");
      print_verdict();
   end
endmodule // tb_top
